/* cpu_clock_power_manager.v */
// Purpose: CPU clock derivation, clock output, idle/power-down and power monitors
// Assumes: ref_clk is the oscillator; cpu clock is given as a one-cycle enable
// Notes:   power-down gates the oscillator enable; the monitors stay live
`timescale 1ns/1ps
`include "clock_power_defines.vh"
// Notes on behaviour
// - Clock output toggles at one sixth of the CPU clock when enabled.
// - Clock output only for RC or external clock; runs while oscillator runs.
// - In external clock mode the second oscillator pin is a port pin unless clock output is enabled.
// - Six CPU clocks per machine cycle; half-speed with divider zero gives twelve oscillator clocks.
// - Divider zero gives oscillator rate, or half with half-speed.
// - Divider N from 1 to 255 divides oscillator by 2*(N+1).
// - Divider may change any time without stopping execution.
// - Brownout resets by default; aux bit 5 selects interrupt instead.
// - Level bit one selects 2.5 V, zero selects 3.8 V.
// - Brownout reset stays asserted while supply stays below threshold.
// - One interrupt per falling crossing, serviced if global and brownout enables.
// - Any brownout activation sets the brownout flag until software clears.
// - Aux bit 6 disables brownout detection entirely.
// - Power-on detection sets the power-on flag until software clears.
// - Idle stops CPU, keeps peripherals; enabled interrupt or reset ends it.
// - Power-down request stops the oscillator.
// - Power-down exits on reset or higher-priority enabled wakeup interrupt.
// - Enabled brownout interrupt crossing wakes from power-down.
// - Wakeup holds execution 1024 clocks for crystal, 256 for RC/external.
// - Watchdog overflow still resets during power-down.
// - Brownout, watchdog and comparators keep running in power-down.
// - Power-down request clears itself when power-down ends.
module cpu_clock_power_manager (
  input  wire       ref_clk,                // oscillator clock
  input  wire       rst,                    // sync reset, active high
  input  wire       ce,                     // clock enable, freezes state
  input  wire [1:0] osc_mode,               // oscillator option
  input  wire       half_speed_config,      // halve CPU clock when divider is zero
  input  wire       brownout_level_select,  // 1: 2.5 V, 0: 3.8 V
  input  wire [7:0] cpu_clock_divider,      // divider value
  input  wire [7:0] aux_control_reg_one,    // aux control bits
  input  wire       clock_out_enable,       // clock output enable
  input  wire       port_pin_out,           // port data for second pin
  input  wire       port_pin_oe,            // port drive enable for second pin
  input  wire       vdd_below_2v5,          // analog comparator, async
  input  wire       vdd_below_3v8,          // analog comparator, async
  input  wire       power_on_detect,        // power-on detector, async
  input  wire       watchdog_overflow,      // watchdog overflow, own osc domain
  input  wire       global_irq_enable,      // interrupt system enable
  input  wire       brownout_irq_enable,    // brownout interrupt enable
  input  wire       wake_irq,               // enabled wakeup irq above current priority
  input  wire       any_irq,                // any enabled interrupt pending
  input  wire       idle_request,           // set idle, one-cycle pulse
  input  wire       powerdown_request,      // set power-down, one-cycle pulse
  input  wire       clear_brownout_flag,    // software clear pulse
  input  wire       clear_power_on_flag,    // software clear pulse
  output reg        cpu_clk_en,             // CPU clock enable pulse
  output reg        machine_cycle_en,       // one per machine cycle
  output reg        periph_clk_en,          // peripheral clock enable
  output reg        osc_running,            // oscillator enable
  output reg        osc_out_clock_pin,      // second pin output value
  output reg        osc_out_pin_oe,         // second pin output enable
  output reg        cpu_reset,              // processor reset request
  output reg        brownout_irq,           // serviced brownout request, pulse
  output reg        brownout_flag,          // sticky brownout flag
  output reg        power_on_flag,          // sticky power-on flag
  output reg        idle_active,            // idle mode state
  output reg        powerdown_active        // power-down request bit
);
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [8:0]  div_cnt;
  reg  [8:0]  div_limit;
  reg  [2:0]  mc_cnt;
  reg  [2:0]  co_cnt;
  reg         co_level;
  reg  [10:0] wake_cnt;
  reg         below_d;
  reg         pon_d;
  wire        below_2v5_s;
  wire        below_3v8_s;
  wire        pon_s;
  wire        wdt_s;
  wire        below;
  wire        bo_disabled;
  wire        bo_irq_mode;
  wire        fall_cross;
  wire        cpu_tick;
  wire        co_allowed;
  wire        osc_en;
  wire [10:0] wake_limit;

  sync3 u_s25 (.ref_clk(ref_clk), .rst(rst), .ce(ce), .async_in(vdd_below_2v5), .sync_out(below_2v5_s));
  sync3 u_s38 (.ref_clk(ref_clk), .rst(rst), .ce(ce), .async_in(vdd_below_3v8), .sync_out(below_3v8_s));
  sync3 u_pon (.ref_clk(ref_clk), .rst(rst), .ce(ce), .async_in(power_on_detect), .sync_out(pon_s));
  sync3 u_wdt (.ref_clk(ref_clk), .rst(rst), .ce(ce), .async_in(watchdog_overflow), .sync_out(wdt_s));

  assign bo_disabled = aux_control_reg_one[`AUX_BROWNOUT_DIS];
  assign bo_irq_mode = aux_control_reg_one[`AUX_BROWNOUT_IRQ];
  assign below       = ~bo_disabled & (brownout_level_select ? below_2v5_s : below_3v8_s);
  assign fall_cross  = below & ~below_d;
  assign osc_en      = (state != `ST_DOWN);
  assign wake_limit  = (osc_mode == `OSC_MODE_RC || osc_mode == `OSC_MODE_EXT) ?
                       `STABLE_RC_COUNT : `STABLE_XTAL_COUNT;
  assign co_allowed  = clock_out_enable & (osc_mode == `OSC_MODE_RC || osc_mode == `OSC_MODE_EXT);

  always @* begin
    if (cpu_clock_divider == 8'h00)
      div_limit = half_speed_config ? 9'h001 : 9'h000;
    else
      div_limit = {cpu_clock_divider, 1'b1};
  end

  assign cpu_tick = osc_en && (div_cnt == 9'h000);

  // divider counter never halts on a change
  always @(posedge ref_clk) begin
    if (rst) begin
      div_cnt <= 9'h000;
    end else if (ce && osc_en) begin
      if (div_cnt == 9'h000)
        div_cnt <= div_limit;
      else
        div_cnt <= div_cnt - 9'h001;
    end
  end

  // six CPU clocks per machine cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      mc_cnt           <= 3'h0;
      cpu_clk_en       <= 1'b0;
      machine_cycle_en <= 1'b0;
      periph_clk_en    <= 1'b0;
    end else if (ce) begin
      // Gated by next mode, so no tick lands on the stop edge
      periph_clk_en    <= cpu_tick && (cpu_reset || next_state != `ST_DOWN);
      // CPU stopped in idle, aligned with idle_active
      cpu_clk_en       <= cpu_tick && (cpu_reset || next_state == `ST_RUN);
      machine_cycle_en <= cpu_tick && (mc_cnt == `CLKOUT_DIV - 3'h1);
      if (cpu_tick)
        mc_cnt <= (mc_cnt == `CLKOUT_DIV - 3'h1) ? 3'h0 : mc_cnt + 3'h1;
    end
  end

  // toggle every three CPU clocks gives one sixth
  always @(posedge ref_clk) begin
    if (rst) begin
      co_cnt   <= 3'h0;
      co_level <= 1'b0;
    end else if (ce) begin
      if (!co_allowed) begin
        co_cnt   <= 3'h0;
        co_level <= 1'b0;
      end else if (cpu_tick) begin
        if (co_cnt == (`CLKOUT_DIV >> 1) - 3'h1) begin
          co_cnt   <= 3'h0;
          co_level <= ~co_level;
        end else begin
          co_cnt <= co_cnt + 3'h1;
        end
      end
    end
  end

  // port pin in external mode unless clock output is on; otherwise pin is off
  always @(posedge ref_clk) begin
    if (rst) begin
      osc_out_clock_pin <= 1'b0;
      osc_out_pin_oe    <= 1'b0;
    end else if (ce) begin
      if (co_allowed) begin
        osc_out_clock_pin <= co_level;
        osc_out_pin_oe    <= 1'b1;
      end else if (osc_mode == `OSC_MODE_EXT) begin
        osc_out_clock_pin <= port_pin_out;
        osc_out_pin_oe    <= port_pin_oe;
      end else begin
        osc_out_clock_pin <= 1'b0;
        osc_out_pin_oe    <= 1'b0;
      end
    end
  end

  always @* begin
    next_state = state;
    case (state)
      `ST_RUN: begin
        if (powerdown_request)
          next_state = `ST_DOWN;
        else if (idle_request)
          next_state = `ST_IDLE;
      end
      `ST_IDLE: begin
        if (any_irq)
          next_state = `ST_RUN;
      end
      `ST_DOWN: begin
        if (wake_irq || (fall_cross && bo_irq_mode && global_irq_enable && brownout_irq_enable))
          next_state = `ST_WAKE;
      end
      `ST_WAKE: begin
        if (wake_cnt >= wake_limit - 11'h001)
          next_state = `ST_RUN;
      end
      default: next_state = `ST_RUN;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state            <= `ST_RUN;
      wake_cnt         <= 11'h000;
      osc_running      <= 1'b1;
      idle_active      <= 1'b0;
      powerdown_active <= 1'b0;
    end else if (ce) begin
      if (cpu_reset) begin
        state <= `ST_RUN;
      end else begin
        state <= next_state;
      end
      wake_cnt <= (state == `ST_WAKE) ? wake_cnt + 11'h001 : 11'h000;
      osc_running      <= cpu_reset || next_state != `ST_DOWN;
      idle_active      <= !cpu_reset && next_state == `ST_IDLE;
      powerdown_active <= !cpu_reset && (next_state == `ST_DOWN || next_state == `ST_WAKE);
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      below_d       <= 1'b0;
      pon_d         <= 1'b0;
      cpu_reset     <= 1'b0;
      brownout_irq  <= 1'b0;
      brownout_flag <= 1'b0;
      power_on_flag <= 1'b0;
    end else if (ce) begin
      below_d <= below;
      pon_d   <= pon_s;
      cpu_reset    <= (below && !bo_irq_mode) || wdt_s || pon_s;
      brownout_irq <= fall_cross && bo_irq_mode && global_irq_enable && brownout_irq_enable;
      if (fall_cross)
        brownout_flag <= 1'b1;
      else if (clear_brownout_flag)
        brownout_flag <= 1'b0;
      if (pon_s && !pon_d)
        power_on_flag <= 1'b1;
      else if (clear_power_on_flag)
        power_on_flag <= 1'b0;
    end
  end
endmodule

/* clock_power_defines.vh */
// Purpose: constants for the CPU clock and power manager
// Assumes: included by bare name
// Notes:   counts are in oscillator-enable cycles of ref_clk
`ifndef CLOCK_POWER_DEFINES_VH
`define CLOCK_POWER_DEFINES_VH
`define CLKOUT_DIV          3'h6
`define DIVIDER_RESET       8'h00
`define STABLE_XTAL_COUNT   11'h400
`define STABLE_RC_COUNT     11'h100
`define OSC_MODE_LOW        2'h0
`define OSC_MODE_MED        2'h1
`define OSC_MODE_RC         2'h2
`define OSC_MODE_EXT        2'h3
`define AUX_BROWNOUT_IRQ    5
`define AUX_BROWNOUT_DIS    6
`define ST_RUN              2'h0
`define ST_IDLE             2'h1
`define ST_DOWN             2'h2
`define ST_WAKE             2'h3
`endif

/* sync3.v */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input asynchronous to ref_clk
// Notes:   output changes when stages two and three agree
`timescale 1ns/1ps
module sync3 (
  input  wire ref_clk,   // clock
  input  wire rst,       // sync reset
  input  wire ce,        // clock enable
  input  wire async_in,  // raw input
  output reg  sync_out   // filtered level
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge ref_clk) begin
    if (rst) begin
      s1       <= 1'b0;
      s2       <= 1'b0;
      s3       <= 1'b0;
      sync_out <= 1'b0;
    end else if (ce) begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        sync_out <= s3;
    end
  end
endmodule

/* cpu_clock_power_manager_sva.sv */
// Purpose: port-level checks of the CPU clock and power manager
// Assumes: bound to every instance of the top module
// Notes:   all checks live in the ref_clk domain
`timescale 1ns/1ps
module cpu_clock_power_manager_sva (
  input wire       ref_clk,              // clock
  input wire       rst,                  // reset
  input wire       ce,                   // enable
  input wire [1:0] osc_mode,             // osc option
  input wire       powerdown_request,    // pd pulse
  input wire       idle_active,          // idle state
  input wire       powerdown_active,     // pd state
  input wire       osc_running,          // osc enable
  input wire       cpu_clk_en,           // cpu tick
  input wire       periph_clk_en,        // periph tick
  input wire       brownout_irq,         // bo request
  input wire       brownout_flag,        // bo flag
  input wire       clear_brownout_flag,  // flag clear
  input wire       global_irq_enable,    // irq enable
  input wire       brownout_irq_enable,  // bo irq enable
  input wire       osc_out_pin_oe        // pin drive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_pd_enter: assert property (ce && powerdown_request && !powerdown_active && !idle_active
    |=> powerdown_active && !osc_running) else $error("power-down not entered");
  a_pd_no_ticks: assert property (!osc_running |-> !cpu_clk_en && !periph_clk_en)
    else $error("tick while oscillator stopped");
  a_idle_cpu_stop: assert property (idle_active |-> !cpu_clk_en) else $error("cpu tick in idle");
  a_bof_sticky: assert property (brownout_flag && ce && !clear_brownout_flag |=> brownout_flag)
    else $error("brownout flag lost");
  a_irq_gated: assert property (brownout_irq |-> global_irq_enable && brownout_irq_enable && brownout_flag)
    else $error("ungated brownout request");
  a_irq_single: assert property (brownout_irq |=> !brownout_irq) else $error("brownout request too long");
  a_xtal_no_out: assert property (!osc_mode[1] && $stable(osc_mode) |-> !osc_out_pin_oe)
    else $error("clock out in crystal mode");
  a_wake_osc_on: assert property ($fell(powerdown_active) |-> osc_running && $past(osc_running))
    else $error("power-down ended without stable oscillator");
  c_pd: cover property (powerdown_active);
  c_idle: cover property (idle_active);
  c_irq: cover property (brownout_irq);
endmodule
bind cpu_clock_power_manager cpu_clock_power_manager_sva u_sva (.*);

/* irq_system_model.sv */
// Purpose: interrupt system seen from the clock and power manager
// Assumes: one pending source with a priority
// Notes:   registered, so requests land one cycle late
`timescale 1ns/1ps
module irq_system_model (
  input  wire       ref_clk,   // clock
  input  wire       rst,       // reset
  input  wire       pend,      // source pending
  input  wire [1:0] src_prio,  // its priority
  input  wire [1:0] run_prio,  // priority in service
  output reg        any_irq,   // enabled irq pending
  output reg        wake_irq   // wake-capable irq
);
  always @(posedge ref_clk) begin
    any_irq <= !rst && pend;
    wake_irq <= !rst && pend && (src_prio > run_prio);
  end
endmodule

/* cpu_clock_power_manager_tb.sv */
// Purpose: self-checking bench for the CPU clock and power manager
// Assumes: inputs move on the falling edge
// Notes:   stability counts are real, so power-down runs are long
`timescale 1ns/1ps
module cpu_clock_power_manager_tb;
  logic ref_clk = 0, rst = 1, ce = 1, half_speed_config = 0, brownout_level_select = 1, clock_out_enable = 1;
  logic port_pin_out = 0, port_pin_oe = 0, vdd_below_2v5 = 0, vdd_below_3v8 = 0, power_on_detect = 0;
  logic watchdog_overflow = 0, global_irq_enable = 1, brownout_irq_enable = 1, idle_request = 0, pend = 0;
  logic powerdown_request = 0, clear_brownout_flag = 0, clear_power_on_flag = 0, prev_pin;
  logic [1:0] osc_mode = 2'h2, src_prio = 2'h3, run_prio = 2'h0, rf;
  logic [7:0] cpu_clock_divider = 8'h00, aux_control_reg_one = 8'h00;
  logic any_irq, wake_irq, cpu_clk_en, machine_cycle_en, periph_clk_en, osc_running, osc_out_clock_pin;
  logic osc_out_pin_oe, cpu_reset, brownout_irq, brownout_flag, power_on_flag, idle_active, powerdown_active;
  int error_cnt = 0, compares = 0, n, c;
  cpu_clock_power_manager dut (.*);
  irq_system_model u_irq (.*);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) prev_pin <= osc_out_clock_pin;
  task tally_and_finish;
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic ev(input int s);
    case (s)
      0: return cpu_clk_en;
      1: return machine_cycle_en;
      2: return osc_out_clock_pin !== prev_pin;
      3: return !powerdown_active;
      4: return !idle_active;
      5: return osc_running;
      default: return cpu_reset;
    endcase
  endfunction
  // Bounded wait; running out is a failure that ends the run
  task automatic wt(input int s, input int lim, output int k);
    k = 0;
    while (ev(s) !== 1'b1) begin
      @(negedge ref_clk);
      k++;
      if (k > lim) begin
        error_cnt++;
        tally_and_finish;
      end
    end
  endtask
  task automatic gap(input int s, output int g);
    wt(s, 4000, g);
    @(negedge ref_clk);
    wt(s, 4000, g);
    g++;
  endtask
  task pdn;
    powerdown_request = 1;
    @(negedge ref_clk);
    powerdown_request = 0;
  endtask
  task automatic t_rate;
    int tbl[4][3] = '{'{0, 0, 1}, '{1, 0, 2}, '{0, 1, 4}, '{0, 255, 512}};
    for (int i = 0; i < 4; i++) begin
      half_speed_config = tbl[i][0][0];
      cpu_clock_divider = tbl[i][1][7:0];
      // Two gaps absorb the change applied at the next wrap
      repeat (2) gap(0, n);
      gap(0, n); chk(n, tbl[i][2]);
      gap(1, n); chk(n, 6 * tbl[i][2]);
      gap(2, n); chk(n, 3 * tbl[i][2]);
    end
    half_speed_config = 0;
    cpu_clock_divider = 8'h00;
    repeat (2) gap(0, n);
  endtask
  task t_pin;
    osc_mode = 2'h3; clock_out_enable = 0; port_pin_oe = 1; port_pin_out = 1;
    repeat (3) @(negedge ref_clk);
    chk({osc_out_pin_oe, osc_out_clock_pin}, 2'h3);
    osc_mode = 2'h0; clock_out_enable = 1;
    repeat (3) @(negedge ref_clk);
    chk(osc_out_pin_oe, 0);
    osc_mode = 2'h2; port_pin_oe = 0;
  endtask
  task t_idle;
    int cc, pc;
    cc = 0; pc = 0;
    idle_request = 1;
    @(negedge ref_clk);
    idle_request = 0;
    repeat (12) begin
      cc += cpu_clk_en; pc += periph_clk_en;
      @(negedge ref_clk);
    end
    chk({idle_active, cc[3:0], pc[3:0]}, {1'b1, 4'h0, 4'hc});
    wt(2, 50, n);
    pend = 1;
    wt(4, 20, n);
    pend = 0;
  endtask
  task automatic t_pd(input logic [1:0] m, input int cnt);
    osc_mode = m;
    pdn;
    chk({powerdown_active, osc_running}, 2'h2);
    pend = 1; src_prio = 2'h1; run_prio = 2'h2;
    repeat (20) @(negedge ref_clk);
    chk({powerdown_active, osc_running, cpu_clk_en}, 3'h4);
    src_prio = 2'h3;
    wt(5, 20, n);
    pend = 0;
    wt(3, 1100, n); chk(n, cnt);
    osc_mode = 2'h2;
  endtask
  // Dip below 2.5 V, count requests, sample reset and flag
  task automatic dip(input logic [7:0] a, input logic en);
    aux_control_reg_one = a; global_irq_enable = en;
    vdd_below_2v5 = 1; c = 0;
    repeat (30) begin
      @(negedge ref_clk);
      c += brownout_irq;
    end
    rf[1] = cpu_reset;
    vdd_below_2v5 = 0;
    repeat (8) @(negedge ref_clk);
    rf[0] = brownout_flag;
    clear_brownout_flag = 1;
    @(negedge ref_clk);
    clear_brownout_flag = 0;
    @(negedge ref_clk);
    chk(brownout_flag, 0);
  endtask
  task t_bo;
    vdd_below_3v8 = 1;
    repeat (8) @(negedge ref_clk);
    chk({cpu_reset, brownout_flag}, 2'h0);
    vdd_below_3v8 = 0;
    dip(8'h00, 1); chk({c[3:0], rf}, 6'h03);
    dip(8'h20, 1); chk({c[3:0], rf}, 6'h05);
    dip(8'h20, 0); chk({c[3:0], rf}, 6'h01);
    dip(8'h40, 1); chk({c[3:0], rf}, 6'h00);
    dip(8'h60, 1); chk({c[3:0], rf}, 6'h00);
  endtask
  task t_wake;
    aux_control_reg_one = 8'h20; global_irq_enable = 1; brownout_level_select = 0;
    pdn;
    vdd_below_3v8 = 1;
    wt(5, 20, n);
    wt(3, 300, n);
    vdd_below_3v8 = 0;
    // Let the level drain through the synchroniser before reset mode returns
    repeat (6) @(negedge ref_clk);
    aux_control_reg_one = 8'h00;
    pdn;
    watchdog_overflow = 1;
    wt(6, 20, n);
    watchdog_overflow = 0; rst = 1;
    repeat (8) @(negedge ref_clk);
    rst = 0;
  endtask
  task t_pof;
    power_on_detect = 1;
    repeat (6) @(negedge ref_clk);
    power_on_detect = 0;
    repeat (20) @(negedge ref_clk);
    chk(power_on_flag, 1);
    clear_power_on_flag = 1;
    @(negedge ref_clk);
    clear_power_on_flag = 0;
    @(negedge ref_clk);
    chk(power_on_flag, 0);
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    rst = 0;
    repeat (2) @(negedge ref_clk);
    t_rate; t_pin; t_idle; t_pd(2'h2, 256); t_pd(2'h0, 1024); t_bo; t_wake; t_pof;
    tally_and_finish;
  end
endmodule
